// >>> atf_consts.vh
/*
  Constants for the timer clock and counter front end.
  Assumes inclusion by bare name from the design files.
*/
// Functional notes
// - Core counter is 16 bits; counts up, down, or alternating up/down.
// - Prescaler divides its input by the prescale value plus one, 1 to 65536.
// - New prescale value takes effect only at an update event, including software request.
// - Counter restarts at the end of each cycle: up from 0, down from the auto-reload value, centre turns back.
// - Repetition counter counts reloads; reaching the limit raises the specific event.
// - Slave mode 000b with timer started and mode 2 disabled clocks the prescaler from the bus clock.
// - Slave mode 111b selects external clock mode 1 from the selected trigger.
// - Trigger sources: internal 0-3, ch1 edge, ch1/ch2 polarised, filtered external clock.
// - External clock mode 2 counts selected edges of the filtered external pin.
// - External pin goes through inverter, divider, then filter.
// - Mode 2 enabled with slave mode 111b forces the trigger to filtered external clock.
// - Slave modes 001b, 010b, 011b use channel 1 and 2 inputs as encoder.
// - Four channels, each either capturing from its own or its neighbour's pin, or driving its own pin.
// - Each input is filtered by a 4-bit setting, edge detected, polarity selected.
// - Capture source is own or neighbour polarised input, then an input prescaler.
// - Software reads and writes reach only the preload register.
// - Capture latches counter into shadow, then copies it to preload.
// - Compare copies preload to shadow and compares shadow with the counter.
// - Selected clock and trigger sources are offered as a trigger output.
`ifndef ATF_CONSTS_VH
`define ATF_CONSTS_VH
`define ATF_SMS_INTERNAL 3'h0
`define ATF_SMS_ENC1     3'h1
`define ATF_SMS_ENC2     3'h2
`define ATF_SMS_ENC3     3'h3
`define ATF_SMS_EXT1     3'h7
`define ATF_TS_ITR0      3'h0
`define ATF_TS_ITR1      3'h1
`define ATF_TS_ITR2      3'h2
`define ATF_TS_ITR3      3'h3
`define ATF_TS_CH1ED     3'h4
`define ATF_TS_CH1FP     3'h5
`define ATF_TS_CH2FP     3'h6
`define ATF_TS_EXT_PIN_FILTERED      3'h7
`define ATF_DIR_UP       2'h0
`define ATF_DIR_DOWN     2'h1
`define ATF_DIR_CENTER   2'h2
`define ATF_SEL_OUTPUT   2'h0
`define ATF_SEL_OWN      2'h1
`define ATF_SEL_NEIGH    2'h2
`define ATF_RST_WORD     16'h0000
`endif

// >>> atf_pin_model.sv
/*
  Far side model: external clock pin and four channel pins.
  Assumes its tasks are called just after a rising clock edge.
*/
`timescale 1ns/1ns
module atf_pin_model (
  // Clock
  input  wire        core_clk,
  // Pins
  output logic       ext_clock_pin,
  output logic [3:0] ch_pin_in
);
  localparam int HALF = 8;
  initial begin
    ext_clock_pin = 1'b0;
    ch_pin_in = 4'h0;
  end
  // Pulses outlast synchronisers and filters
  task automatic ext_pulses(input int k);
    repeat (k) begin
      ext_clock_pin = 1'b1;
      repeat (HALF) @(posedge core_clk);
      #1 ext_clock_pin = 1'b0;
      repeat (HALF) @(posedge core_clk);
      #1;
    end
  endtask
  // Quadrature on ch1/ch2; rev makes ch2 lead
  task automatic quad(input logic rev, input int k);
    logic [3:0] step [4];
    step = '{4'h1, 4'h3, 4'h2, 4'h0};
    repeat (k) begin
      for (int j = 0; j < 4; j++) begin
        ch_pin_in = rev ? {2'h0, step[j][0], step[j][1]} : step[j];
        repeat (HALF) @(posedge core_clk);
        #1;
      end
    end
  endtask
  task automatic ch_pulses(input logic [3:0] m, input int k);
    repeat (k) begin
      ch_pin_in = m;
      repeat (HALF) @(posedge core_clk);
      #1 ch_pin_in = 4'h0;
      repeat (HALF) @(posedge core_clk);
      #1;
    end
  endtask
endmodule // atf_pin_model

// >>> atf_timer.v
/*
  Timer front end: clock source selection, prescaler, auto-reload counter
  with repetition counter, and four compare/capture channels.
  Assumes all inputs synchronous to core_clk; configuration held steady by software.
*/
`timescale 1ns/1ns
`include "atf_consts.vh"
module atf_timer (
  // Clock and reset
  input  wire        core_clk,
  input  wire        sys_rst,
  // Control
  input  wire        timer_enable,
  input  wire [2:0]  slave_mode_select,
  input  wire [2:0]  trigger_source_select,
  input  wire        ext_clock2_enable,
  input  wire [1:0]  count_direction,
  input  wire        soft_update_request,
  input  wire [15:0] prescale_value,
  input  wire [15:0] auto_reload_value,
  input  wire [7:0]  repetition_limit,
  // External pin and internal triggers
  input  wire        ext_clock_pin,
  input  wire        ext_pin_invert,
  input  wire [1:0]  ext_pin_divider,
  input  wire [3:0]  ext_pin_filter,
  input  wire [3:0]  internal_trigger_n,
  // Channel pins
  input  wire [3:0]  ch_pin_in,
  output reg  [3:0]  ch_pin_out,
  output wire [3:0]  ch_pin_oe_n,
  // Channel configuration, 4 per-channel fields packed
  input  wire [15:0] input_filter_setting,
  input  wire [3:0]  ch_polarity,
  input  wire [7:0]  ch_input_select,
  input  wire [7:0]  input_prescale,
  // Compare/capture preload access
  input  wire [3:0]  ccr_write,
  input  wire [63:0] ccr_wdata,
  output wire [63:0] channel_compare_value,
  output reg  [3:0]  capture_event,
  // Status
  output reg  [15:0] core_counter,
  output reg         count_down_q,
  output reg         update_event,
  output reg         repetition_event,
  output reg         trigger_output
);

  // ----------------------------------------
  // Filter function
  // ----------------------------------------
  function [3:0] flt_len;
    input [3:0] s;
    begin
      flt_len = (s == 4'h0) ? 4'h0 : s;
    end
  endfunction

  // ----------------------------------------
  // External pin path
  // ----------------------------------------
  reg  [3:0] ext_div_cnt_q;
  reg        ext_pin_divided;
  reg        ext_raw_q;
  reg  [3:0] ext_flt_cnt_q;
  reg        ext_pin_filtered;
  reg        ext_pin_filtered_prev_q;
  wire       ext_inv = ext_clock_pin ^ ext_pin_invert;
  reg        ext_inv_q;
  wire       ext_rise = ext_inv & ~ext_inv_q;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      ext_inv_q       <= 1'b0;
      ext_div_cnt_q   <= 4'h0;
      ext_pin_divided <= 1'b0;
      ext_raw_q       <= 1'b0;
      ext_flt_cnt_q   <= 4'h0;
      ext_pin_filtered <= 1'b0;
      ext_pin_filtered_prev_q     <= 1'b0;
    end else begin
      ext_inv_q <= ext_inv;
      if (ext_pin_divider == 2'h0) begin
        ext_pin_divided <= ext_inv;
      end else if (ext_rise) begin
        if (ext_div_cnt_q[2:0] == ((3'h1 << ext_pin_divider) - 3'h1) >> 1 ||
            ext_div_cnt_q[2:0] == (3'h1 << ext_pin_divider) - 3'h1) begin
          ext_pin_divided <= ~ext_pin_divided;
        end
        ext_div_cnt_q <= (ext_div_cnt_q[2:0] == (3'h1 << ext_pin_divider) - 3'h1) ?
                         4'h0 : ext_div_cnt_q + 4'h1;
      end
      ext_raw_q <= ext_pin_divided;
      if (ext_raw_q == ext_pin_filtered) begin
        ext_flt_cnt_q <= 4'h0;
      end else if (ext_flt_cnt_q >= flt_len(ext_pin_filter)) begin
        ext_pin_filtered <= ext_raw_q;
        ext_flt_cnt_q    <= 4'h0;
      end else begin
        ext_flt_cnt_q <= ext_flt_cnt_q + 4'h1;
      end
      ext_pin_filtered_prev_q <= ext_pin_filtered;
    end
  end
  wire ext_pin_filtered_edge = ext_pin_filtered & ~ext_pin_filtered_prev_q;

  // ----------------------------------------
  // Channel input filters and edges
  // ----------------------------------------
  reg  [3:0] ch_raw_q;
  reg  [3:0] ch_flt_q;
  reg  [3:0] ch_flt_prev_q;
  reg  [15:0] ch_flt_cnt_q;
  wire [3:0] ch_pol;
  wire [3:0] ch_pol_edge;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_in
      always @(posedge core_clk) begin
        if (sys_rst) begin
          ch_raw_q[g]          <= 1'b0;
          ch_flt_q[g]          <= 1'b0;
          ch_flt_prev_q[g]     <= 1'b0;
          ch_flt_cnt_q[4*g+:4] <= 4'h0;
        end else begin
          ch_raw_q[g]      <= ch_pin_in[g];
          ch_flt_prev_q[g] <= ch_flt_q[g];
          if (ch_raw_q[g] == ch_flt_q[g]) begin
            ch_flt_cnt_q[4*g+:4] <= 4'h0;
          end else if (ch_flt_cnt_q[4*g+:4] >= flt_len(input_filter_setting[4*g+:4])) begin
            ch_flt_q[g]          <= ch_raw_q[g];
            ch_flt_cnt_q[4*g+:4] <= 4'h0;
          end else begin
            ch_flt_cnt_q[4*g+:4] <= ch_flt_cnt_q[4*g+:4] + 4'h1;
          end
        end
      end
      // Polarised level and its active edge
      assign ch_pol[g]      = ch_flt_q[g] ^ ch_polarity[g];
      assign ch_pol_edge[g] = ch_polarity[g] ? (~ch_flt_q[g] & ch_flt_prev_q[g]) :
                                               (ch_flt_q[g] & ~ch_flt_prev_q[g]);
    end
  endgenerate
  wire ch1_edge_detect      = ch_flt_q[0] ^ ch_flt_prev_q[0];
  wire ch1_polarised_to_ch1 = ch_pol_edge[0];
  wire ch2_polarised_to_ch2 = ch_pol_edge[1];

  // ----------------------------------------
  // Trigger and clock source selection
  // ----------------------------------------
  reg  [3:0] itr_prev_q;
  reg        trigger_input;
  always @* begin
    trigger_input = 1'b0;
    if (ext_clock2_enable && slave_mode_select == `ATF_SMS_EXT1) begin
      trigger_input = ext_pin_filtered_edge;
    end else begin
      case (trigger_source_select)
        `ATF_TS_ITR0:  trigger_input = internal_trigger_n[0] & ~itr_prev_q[0];
        `ATF_TS_ITR1:  trigger_input = internal_trigger_n[1] & ~itr_prev_q[1];
        `ATF_TS_ITR2:  trigger_input = internal_trigger_n[2] & ~itr_prev_q[2];
        `ATF_TS_ITR3:  trigger_input = internal_trigger_n[3] & ~itr_prev_q[3];
        `ATF_TS_CH1ED: trigger_input = ch1_edge_detect;
        `ATF_TS_CH1FP: trigger_input = ch1_polarised_to_ch1;
        `ATF_TS_CH2FP: trigger_input = ch2_polarised_to_ch2;
        default:       trigger_input = ext_pin_filtered_edge;
      endcase
    end
  end

  // Encoder: count on ch1 and/or ch2 edges, direction from the other level
  wire enc_a  = ch_pol[0] ^ ch_flt_prev_q[0] ^ ch_polarity[0];
  wire enc_b  = ch_pol[1] ^ ch_flt_prev_q[1] ^ ch_polarity[1];
  wire enc_on = (slave_mode_select == `ATF_SMS_ENC1) ||
                (slave_mode_select == `ATF_SMS_ENC2) ||
                (slave_mode_select == `ATF_SMS_ENC3);
  wire enc_tick = ((slave_mode_select != `ATF_SMS_ENC1) & enc_a) |
                  ((slave_mode_select != `ATF_SMS_ENC2) & enc_b);
  wire enc_down = enc_a ? (ch_pol[0] == ch_pol[1]) : (ch_pol[0] != ch_pol[1]);

  reg prescaler_in_clock;
  always @* begin
    if (!timer_enable) begin
      prescaler_in_clock = 1'b0;
    end else if (enc_on) begin
      prescaler_in_clock = enc_tick;
    end else if (slave_mode_select == `ATF_SMS_EXT1) begin
      prescaler_in_clock = trigger_input;
    end else if (ext_clock2_enable) begin
      prescaler_in_clock = ext_pin_filtered_edge;
    end else begin
      prescaler_in_clock = 1'b1;
    end
  end

  // ----------------------------------------
  // Prescaler, counter, repetition
  // ----------------------------------------
  reg  [15:0] psc_active_q;
  reg  [15:0] psc_cnt_q;
  reg  [7:0]  rep_cnt_q;
  wire        counter_clock = prescaler_in_clock && (psc_cnt_q == psc_active_q);
  wire        go_down = enc_on ? enc_down :
                        (count_direction == `ATF_DIR_DOWN) ||
                        (count_direction == `ATF_DIR_CENTER && count_down_q);
  wire        wrap = counter_clock &&
                     (go_down ? (core_counter == 16'h0000) :
                                (core_counter == auto_reload_value));
  wire        upd = wrap || soft_update_request;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      psc_active_q     <= `ATF_RST_WORD;
      psc_cnt_q        <= `ATF_RST_WORD;
      core_counter     <= `ATF_RST_WORD;
      count_down_q     <= 1'b0;
      rep_cnt_q        <= 8'h00;
      update_event     <= 1'b0;
      repetition_event <= 1'b0;
      itr_prev_q       <= 4'h0;
      trigger_output   <= 1'b0;
    end else begin
      itr_prev_q     <= internal_trigger_n;
      trigger_output <= prescaler_in_clock | trigger_input;
      update_event     <= upd;
      repetition_event <= 1'b0;
      if (upd) begin
        psc_active_q <= prescale_value;
      end
      if (soft_update_request) begin
        psc_cnt_q    <= 16'h0000;
        core_counter <= (go_down && count_direction != `ATF_DIR_CENTER) ?
                        auto_reload_value : 16'h0000;
        rep_cnt_q    <= 8'h00;
      end else if (prescaler_in_clock) begin
        psc_cnt_q <= (psc_cnt_q == psc_active_q) ? 16'h0000 : psc_cnt_q + 16'h0001;
        if (counter_clock) begin
          if (wrap) begin
            if (count_direction == `ATF_DIR_CENTER && !enc_on) begin
              count_down_q <= ~count_down_q;
              core_counter <= go_down ? 16'h0001 : auto_reload_value - 16'h0001;
            end else begin
              core_counter <= go_down ? auto_reload_value : 16'h0000;
            end
            if (rep_cnt_q == repetition_limit) begin
              rep_cnt_q        <= 8'h00;
              repetition_event <= 1'b1;
            end else begin
              rep_cnt_q <= rep_cnt_q + 8'h01;
            end
          end else begin
            core_counter <= go_down ? core_counter - 16'h0001 : core_counter + 16'h0001;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Compare/capture channels
  // ----------------------------------------
  reg [63:0] ccr_pre_q;
  reg [63:0] ccr_shadow_q;
  reg [11:0] input_prescale_cnt_q;
  assign channel_compare_value = ccr_pre_q;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ch
      wire [1:0] sel = ch_input_select[2*g+:2];
      wire       cap_src = (sel == `ATF_SEL_OWN) ? ch_pol_edge[g] :
                           ch_pol_edge[g ^ 1];
      wire       is_in = (sel != `ATF_SEL_OUTPUT);
      wire [2:0] input_prescale_top = (3'h1 << input_prescale[2*g+:2]) - 3'h1;
      wire       cap_fire = is_in && cap_src && (input_prescale_cnt_q[3*g+:3] == input_prescale_top);
      reg        cap_pend_q;
      assign ch_pin_oe_n[g] = is_in;
      always @(posedge core_clk) begin
        if (sys_rst) begin
          ccr_pre_q[16*g+:16]    <= `ATF_RST_WORD;
          ccr_shadow_q[16*g+:16] <= `ATF_RST_WORD;
          input_prescale_cnt_q[3*g+:3]     <= 3'h0;
          cap_pend_q             <= 1'b0;
          capture_event[g]       <= 1'b0;
          ch_pin_out[g]          <= 1'b0;
        end else begin
          capture_event[g] <= cap_pend_q;
          cap_pend_q       <= cap_fire;
          if (is_in && cap_src) begin
            input_prescale_cnt_q[3*g+:3] <= cap_fire ? 3'h0 : input_prescale_cnt_q[3*g+:3] + 3'h1;
          end
          if (is_in) begin
            if (cap_fire) begin
              ccr_shadow_q[16*g+:16] <= core_counter;
            end
            if (cap_pend_q) begin
              ccr_pre_q[16*g+:16] <= ccr_shadow_q[16*g+:16];
            end
            ch_pin_out[g] <= 1'b0;
          end else begin
            if (ccr_write[g]) begin
              ccr_pre_q[16*g+:16] <= ccr_wdata[16*g+:16];
            end
            ccr_shadow_q[16*g+:16] <= ccr_pre_q[16*g+:16];
            ch_pin_out[g] <= (core_counter < ccr_shadow_q[16*g+:16]);
          end
        end
      end
    end
  endgenerate

endmodule // atf_timer

// >>> atf_timer_checker.sv
/*
  Concurrent checks on the timer front end ports.
  Assumes one core_clk domain and a bind onto atf_timer.
*/
`timescale 1ns/1ns
module atf_timer_checker (
  // Clock and reset
  input wire        core_clk,
  input wire        sys_rst,
  // Control
  input wire        timer_enable,
  input wire [1:0]  count_direction,
  input wire        soft_update_request,
  input wire [15:0] auto_reload_value,
  input wire [7:0]  ch_input_select,
  input wire [3:0]  ccr_write,
  input wire [63:0] ccr_wdata,
  // Observed
  input wire [3:0]  ch_pin_oe_n,
  input wire [63:0] channel_compare_value,
  input wire [3:0]  capture_event,
  input wire [15:0] core_counter,
  input wire        update_event
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // --------------------------------
  // Sequences
  // --------------------------------
  sequence s_up_wrap;
    count_direction == 2'h0 && !soft_update_request && auto_reload_value != 16'h0000
      && core_counter == auto_reload_value ##1 core_counter == 16'h0000;
  endsequence
  sequence s_refused_write;
    ch_input_select[1:0] != 2'h0 && ccr_write[0] ##1 !capture_event[0];
  endsequence
  // --------------------------------
  // Assertions
  // --------------------------------
  a_reset_clears: assert property (@(posedge core_clk) disable iff (1'b0)
    sys_rst |=> core_counter == 16'h0000 && !update_event) else $error("reset state wrong");
  a_up_step: assert property (count_direction == 2'h0 && $past(count_direction) == 2'h0
    && !$past(soft_update_request) && $changed(core_counter)
    |-> core_counter == $past(core_counter) + 16'h0001 || core_counter == 16'h0000)
    else $error("up count step wrong");
  a_down_step: assert property (count_direction == 2'h1 && $past(count_direction) == 2'h1
    && !$past(soft_update_request) && $changed(core_counter)
    |-> core_counter == $past(core_counter) - 16'h0001 || core_counter == auto_reload_value)
    else $error("down count step wrong");
  a_wrap_update: assert property (s_up_wrap |-> ##[0:1] update_event)
    else $error("no update after wrap");
  a_hold_off: assert property (!timer_enable && !soft_update_request |=> $stable(core_counter))
    else $error("counter moved while stopped");
  a_oe_select: assert property (ch_pin_oe_n == {|ch_input_select[7:6], |ch_input_select[5:4],
    |ch_input_select[3:2], |ch_input_select[1:0]}) else $error("pin enable wrong");
  a_write_preload: assert property (ch_input_select[1:0] == 2'h0 && ccr_write[0]
    |=> channel_compare_value[15:0] == $past(ccr_wdata[15:0])) else $error("write lost");
  a_write_refused: assert property (s_refused_write |-> $stable(channel_compare_value[15:0]))
    else $error("write taken in input mode");
  a_capture_moves: assert property ($changed(channel_compare_value[15:0])
    && !$past(ccr_write[0]) |-> capture_event[0]) else $error("preload changed silently");
endmodule // atf_timer_checker

bind atf_timer atf_timer_checker i_chk (.*);

// >>> atf_timer_tb_top.sv
/*
  Self-checking bench for the timer front end.
  Assumes the checker is bound and the pin model drives the pins.
*/
`timescale 1ns/1ns
module atf_timer_tb_top;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        timer_enable = 1'b0;
  logic [2:0]  slave_mode_select = 3'h0;
  logic [2:0]  trigger_source_select = 3'h0;
  logic        ext_clock2_enable = 1'b0;
  logic [1:0]  count_direction = 2'h0;
  logic        soft_update_request = 1'b0;
  logic [15:0] prescale_value = 16'h0000;
  logic [15:0] auto_reload_value = 16'h0003;
  logic [7:0]  repetition_limit = 8'h00;
  logic        ext_pin_invert = 1'b0;
  logic [1:0]  ext_pin_divider = 2'h0;
  logic [3:0]  ext_pin_filter = 4'h0;
  logic [3:0]  internal_trigger_n = 4'h0;
  logic [15:0] input_filter_setting = 16'h0002;
  logic [3:0]  ch_polarity = 4'h0;
  logic [7:0]  ch_input_select = 8'h00;
  logic [7:0]  input_prescale = 8'h00;
  logic [3:0]  ccr_write = 4'h0;
  logic [63:0] ccr_wdata = 64'h0;
  logic        ext_clock_pin, count_down_q, update_event, repetition_event, trigger_output;
  logic [3:0]  ch_pin_in, ch_pin_out, ch_pin_oe_n, capture_event;
  logic [63:0] channel_compare_value;
  logic [15:0] core_counter;
  int          n_errors = 0;
  int          checks_done = 0;
  int          n, k;

  atf_timer i_dut (.*);
  atf_pin_model i_pins (.core_clk(core_clk), .ext_clock_pin(ext_clock_pin), .ch_pin_in(ch_pin_in));

  always #10 core_clk = ~core_clk;
  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic tick(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic soft_update;
    soft_update_request = 1'b1;
    tick(1);
    soft_update_request = 1'b0;
    tick(1);
  endtask
  task automatic wait_cnt(input logic [15:0] v);
    n = 0;
    while (core_counter !== v && n < 200) begin tick(1); n++; end
    chk(core_counter, v);
  endtask
  task automatic gap(input int exp);
    logic [15:0] c;
    c = core_counter; n = 0;
    while (core_counter === c && n < 100) begin tick(1); n++; end
    c = core_counter; n = 0;
    while (core_counter === c && n < 100) begin tick(1); n++; end
    chk(n, exp);
  endtask
  task automatic trig(input logic [3:0] m, input int c);
    repeat (c) begin internal_trigger_n = m; tick(4); internal_trigger_n = 4'h0; tick(4); end
  endtask
  task automatic ccw(input logic [15:0] v);
    ccr_wdata = {48'h0, v}; ccr_write = 4'h1; tick(1); ccr_write = 4'h0; tick(2);
  endtask
  task automatic conclude;
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // --------------------------------
  // Tests
  // --------------------------------
  initial begin
    tick(2); sys_rst = 1'b0;
    chk({core_counter, ch_pin_oe_n, update_event, repetition_event}, 22'h0);
    timer_enable = 1'b1;
    wait_cnt(16'h0001);
    for (int i = 2; i < 7; i++) begin tick(1); chk(core_counter, i % 4); end
    auto_reload_value = 16'h00ff; prescale_value = 16'h0002;
    gap(1);
    soft_update;
    gap(3);
    prescale_value = 16'h0000; auto_reload_value = 16'h0003; repetition_limit = 8'h01;
    soft_update; tick(3); n = 0; k = 0;
    repeat (40) begin tick(1); n += update_event; k += repetition_event; end
    chk(n, 10);
    chk(k, 5);
    count_direction = 2'h1; soft_update;
    wait_cnt(16'h0002);
    for (int i = 1; i < 5; i++) begin tick(1); chk(core_counter, (6 - i) % 4); end
    count_direction = 2'h2; soft_update;
    for (int i = 0; i < 6; i++) begin
      tick(1);
      chk(core_counter, i < 2 ? i + 2 : (i < 5 ? 4 - i : i - 4));
    end
    count_direction = 2'h0; auto_reload_value = 16'hffff;
    slave_mode_select = 3'h7; ch_input_select = 8'h05;
    for (int s = 0; s < 8; s++) begin
      trigger_source_select = s[2:0]; soft_update; tick(2);
      if (s < 4) begin trig(4'hf ^ (4'h1 << s), 2); trig(4'h1 << s, 3); end
      else if (s == 7) i_pins.ext_pulses(3);
      else i_pins.ch_pulses(s == 6 ? 4'h2 : 4'h1, 3);
      tick(8);
      chk(core_counter, s == 4 ? 6 : 3);
    end
    slave_mode_select = 3'h0; ext_clock2_enable = 1'b1; ext_pin_divider = 2'h1;
    soft_update; tick(2); i_pins.ext_pulses(6); tick(8);
    chk(core_counter, 16'h0003);
    slave_mode_select = 3'h7; trigger_source_select = 3'h0; ext_pin_divider = 2'h0;
    soft_update; tick(2); i_pins.ext_pulses(4); tick(8);
    chk(core_counter, 16'h0004);
    slave_mode_select = 3'h3; ext_clock2_enable = 1'b0;
    soft_update; tick(2); i_pins.quad(1'b0, 2); tick(8);
    chk(core_counter, 16'h0008);
    count_direction = 2'h1; i_pins.quad(1'b1, 1); tick(8);
    chk(core_counter, 16'h0004);
    count_direction = 2'h0;
    slave_mode_select = 3'h0; ext_clock2_enable = 1'b0; timer_enable = 1'b0;
    ch_input_select = 8'h09; tick(2); i_pins.ch_pulses(4'h1, 1); tick(8);
    chk(channel_compare_value[31:0], 32'h0004_0004);
    ccw(16'h1234);
    chk(channel_compare_value[15:0], 16'h0004);
    ch_input_select = 8'h08; ccw(16'h1234);
    chk({ch_pin_oe_n, channel_compare_value[15:0]}, 20'h21234);
    soft_update; tick(2);
    chk(ch_pin_out[0], 1'b1);
    ccw(16'h0000); soft_update; tick(2);
    chk(ch_pin_out[0], 1'b0);
    conclude;
  end
  initial begin
    tick(6000);
    n_errors++;
    conclude;
  end
endmodule // atf_timer_tb_top
